// >>> ipsc_top.sv
// interrupt priority select and external request sense/pending control
// assumes one 100 MHz clock, avalon-mm master, core pulses acceptance per request
// Operation
// - priority a clears on reset and standby
// - a bit7 ext0 level, bit6 ext1
// - a bit5 ext2/3, bit4 ext4/5 shared
// - a bit3 watchdog plus refresh shared
// - a bits2..0 timer channels 0..2
// - bit 0 low level, 1 high
// - priority b clears on reset and standby
// - b bit7 timer3, bit6 timer4
// - b bit5 dma channels 0/1 shared
// - b bit3 serial0, bit2 serial1
// - b bit1 converter level
// - b bits 4,0 stored, no effect
// - pending clears on reset and standby
// - pending bits 7,6 read zero
// - flag sets on low level or fall
// - clear by zero after reading one
// - acceptance clears edge; level if high
// - enable bit gates each request
// - enable clears on reset and standby
// - enable/sense bits 7,6 plain storage
// - sense 0 level, 1 falling edge
// - sense clears on reset and standby
// - pins sampled regardless of direction
`include "ipsc_consts.svh"
`default_nettype none

module ipsc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // avalon-mm slave
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // hardware standby level
  input wire logic i_hw_standby,
  // external request pins, active low
  input wire logic [5:0] i_ext_request_pin_n,
  // core acceptance pulses, one per request
  input wire logic [5:0] i_ext_accept,
  // requests and their levels to the core
  output ipsc_pkg::ipsc_ext_t o_ext_request,
  output ipsc_pkg::ipsc_ext_t o_ext_level,
  // internal group levels: tmr0..4, wdt_rfsh, dma, ser0, ser1, adc
  output logic [9:0] o_int_level
);
  import ipsc_pkg::*;

  // ***********************************************
  // storage
  // ***********************************************
  ipsc_byte_t priority_select_a_reg; // first priority register
  ipsc_byte_t priority_select_b_reg; // second priority register
  ipsc_ext_t ext_pending_reg; // pending flags 5..0
  ipsc_byte_t ext_request_enable_reg; // enable, bits 7,6 spare
  ipsc_byte_t ext_request_sense_reg; // sense, bits 7,6 spare
  logic soft_standby_reg; // software standby request
  ipsc_ext_t read_one_reg; // flag seen as 1 by a read
  ipsc_ext_t pin_prev_reg; // last filtered pin level
  ipsc_bus_e bus_reg; // slave answer state
  ipsc_ext_t pin_level; // filtered pins
  logic stby_hold; // combined standby clear
  logic stby_sync1_reg; // standby pin synchroniser
  logic stby_sync2_reg;
  logic stby_sync3_reg;
  logic stby_level_reg;

  // ***********************************************
  // helper functions
  // ***********************************************
  // byte-lane merge on lane zero only
  function automatic ipsc_byte_t lane_merge(input ipsc_byte_t old_v, input logic [31:0] wd,
                                            input logic [3:0] be);
    lane_merge = be[0] ? wd[7:0] : old_v;
  endfunction

  // address hit for a write on the answering edge
  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] target, input logic wr,
                                  input logic st);
    wr_hit = wr && st && (a == target);
  endfunction

  // ***********************************************
  // pin synchronisation
  // ***********************************************
  // pins sampled whatever their direction setting
  ipsc_sync #(
    .WIDTH(`IPSC_EXT_N)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_ext_request_pin_n),
    .o_level(pin_level)
  );

  // standby pin through three stages, agreement filter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stby_sync1_reg <= 1'b0;
      stby_sync2_reg <= 1'b0;
      stby_sync3_reg <= 1'b0;
      stby_level_reg <= 1'b0;
    end else begin
      stby_sync1_reg <= i_hw_standby;
      stby_sync2_reg <= stby_sync1_reg;
      stby_sync3_reg <= stby_sync2_reg;
      if (stby_sync2_reg == stby_sync3_reg) begin
        stby_level_reg <= stby_sync3_reg;
      end
    end
  end

  // either standby source clears the priority, enable, sense, pending and read-one registers
  assign stby_hold = stby_level_reg | soft_standby_reg;

  // ***********************************************
  // bus slave: one wait cycle, then answer
  // ***********************************************
  logic bus_go; // answering edge
  assign bus_go = (bus_reg == IPSC_ACK);

  // waitrequest high by default; drops for one cycle to answer
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_reg <= IPSC_IDLE;
      o_waitrequest <= 1'b1;
    end else begin
      case (bus_reg)
        IPSC_IDLE: begin
          if (i_read || i_write) begin
            bus_reg <= IPSC_ACK;
            o_waitrequest <= 1'b0;
          end
        end
        IPSC_ACK: begin
          bus_reg <= IPSC_IDLE;
          o_waitrequest <= 1'b1;
        end
        default: begin
          bus_reg <= IPSC_IDLE;
          o_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read data built together with the waitrequest drop
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_readdata <= 32'h0000_0000;
    end else if (bus_reg == IPSC_IDLE && i_read) begin
      case (i_address)
        `IPSC_ADDR_PRI_A: o_readdata <= {24'h00_0000, priority_select_a_reg};
        `IPSC_ADDR_PRI_B: o_readdata <= {24'h00_0000, priority_select_b_reg};
        // upper flags read zero
        `IPSC_ADDR_PEND: o_readdata <= {26'h000_0000, ext_pending_reg};
        `IPSC_ADDR_EN: o_readdata <= {24'h00_0000, ext_request_enable_reg};
        `IPSC_ADDR_SENSE: o_readdata <= {24'h00_0000, ext_request_sense_reg};
        `IPSC_ADDR_CTRL: o_readdata <= {31'h0000_0000, soft_standby_reg};
        // unmapped words read zero
        default: o_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************
  // priority registers
  // ***********************************************
  // reset and standby clear; plain storage of all bits
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      priority_select_a_reg <= `IPSC_RST_BYTE;
      priority_select_b_reg <= `IPSC_RST_BYTE;
    end else if (stby_hold) begin
      priority_select_a_reg <= `IPSC_RST_BYTE;
      priority_select_b_reg <= `IPSC_RST_BYTE;
    end else begin
      if (wr_hit(i_address, `IPSC_ADDR_PRI_A, i_write, bus_go)) begin
        priority_select_a_reg <= lane_merge(priority_select_a_reg, i_writedata, i_byteenable);
      end
      if (wr_hit(i_address, `IPSC_ADDR_PRI_B, i_write, bus_go)) begin
        priority_select_b_reg <= lane_merge(priority_select_b_reg, i_writedata, i_byteenable);
      end
    end
  end

  // ***********************************************
  // enable and sense registers
  // ***********************************************
  // all eight bits stored; only 5..0 steer logic
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_request_enable_reg <= `IPSC_RST_BYTE;
      ext_request_sense_reg <= `IPSC_RST_BYTE;
    end else if (stby_hold) begin
      ext_request_enable_reg <= `IPSC_RST_BYTE;
      ext_request_sense_reg <= `IPSC_RST_BYTE;
    end else begin
      if (wr_hit(i_address, `IPSC_ADDR_EN, i_write, bus_go)) begin
        ext_request_enable_reg <= lane_merge(ext_request_enable_reg, i_writedata, i_byteenable);
      end
      if (wr_hit(i_address, `IPSC_ADDR_SENSE, i_write, bus_go)) begin
        ext_request_sense_reg <= lane_merge(ext_request_sense_reg, i_writedata, i_byteenable);
      end
    end
  end

  // software standby control word; reset or a write of zero clears it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      soft_standby_reg <= 1'b0;
    end else if (wr_hit(i_address, `IPSC_ADDR_CTRL, i_write, bus_go) && i_byteenable[0]) begin
      soft_standby_reg <= i_writedata[`IPSC_CTRL_STBY_BIT];
    end
  end

  // ***********************************************
  // pending flags
  // ***********************************************
  // previous filtered level for fall detection
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_prev_reg <= '1;
    end else begin
      pin_prev_reg <= pin_level;
    end
  end

  // remember which flags a read returned as one
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      read_one_reg <= '0;
    end else if (stby_hold) begin
      read_one_reg <= '0;
    end else if (bus_go && i_read && i_address == `IPSC_ADDR_PEND) begin
      // arm from the word software really takes, not the live flags:
      // a flag that rises during the wait state was never seen as one
      read_one_reg <= read_one_reg | o_readdata[`IPSC_EXT_N-1:0];
    end else if (wr_hit(i_address, `IPSC_ADDR_PEND, i_write, bus_go) && i_byteenable[0]) begin
      read_one_reg <= read_one_reg & i_writedata[5:0];
    end
  end

  ipsc_ext_t set_vec; // hardware set term per flag
  ipsc_ext_t clr_vec; // software or core clear term per flag

  // per-flag set and clear terms, kept apart from the flag store
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    for (int n = 0; n < `IPSC_EXT_N; n++) begin
      // level mode sets while low, edge mode on fall
      if (!ext_request_sense_reg[n]) begin
        set_vec[n] = !pin_level[n];
      end else begin
        set_vec[n] = pin_prev_reg[n] && !pin_level[n];
      end
      // write of zero clears only after a read of one
      if (wr_hit(i_address, `IPSC_ADDR_PEND, i_write, bus_go) && i_byteenable[0] &&
          !i_writedata[n] && read_one_reg[n]) begin
        clr_vec[n] = 1'b1;
      end
      // acceptance clears: edge always, level only with pin high
      if (i_ext_accept[n] && (ext_request_sense_reg[n] || pin_level[n])) begin
        clr_vec[n] = 1'b1;
      end
    end
  end

  // flag store; standby clear wins, else set beats a write or acceptance clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_pending_reg <= '0;
    end else if (stby_hold) begin
      ext_pending_reg <= '0;
    end else begin
      ext_pending_reg <= set_vec | (ext_pending_reg & ~clr_vec);
    end
  end

  // ***********************************************
  // outputs to the core
  // ***********************************************
  // request needs flag and enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_request <= '0;
    end else begin
      o_ext_request <= ext_pending_reg & ext_request_enable_reg[5:0];
    end
  end

  // external levels; 0 low, 1 high
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_level <= '0;
    end else begin
      o_ext_level <= {priority_select_a_reg[`IPSC_BIT_A_EXT45], priority_select_a_reg[`IPSC_BIT_A_EXT45],
                      priority_select_a_reg[`IPSC_BIT_A_EXT23], priority_select_a_reg[`IPSC_BIT_A_EXT23],
                      priority_select_a_reg[`IPSC_BIT_A_EXT1], priority_select_a_reg[`IPSC_BIT_A_EXT0]};
    end
  end

  // internal group levels; b bits 4 and 0 unused
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_int_level <= '0;
    end else begin
      o_int_level <= {priority_select_b_reg[`IPSC_BIT_B_ADC], priority_select_b_reg[`IPSC_BIT_B_SER1],
                      priority_select_b_reg[`IPSC_BIT_B_SER0], priority_select_b_reg[`IPSC_BIT_B_DMA],
                      priority_select_a_reg[`IPSC_BIT_A_WDT_RFSH], priority_select_b_reg[`IPSC_BIT_B_TMR4],
                      priority_select_b_reg[`IPSC_BIT_B_TMR3], priority_select_a_reg[`IPSC_BIT_A_TMR2],
                      priority_select_a_reg[`IPSC_BIT_A_TMR1], priority_select_a_reg[`IPSC_BIT_A_TMR0]};
    end
  end

endmodule

`default_nettype wire

// >>> ipsc_consts.svh
// constants for the interrupt priority and sense control block
// assumes inclusion by bare name from each design file
`ifndef IPSC_CONSTS_SVH
`define IPSC_CONSTS_SVH

// ***********************************************
// register word addresses (avalon word index)
// ***********************************************
`define IPSC_ADDR_PRI_A 3'h0
`define IPSC_ADDR_PRI_B 3'h1
`define IPSC_ADDR_PEND 3'h2
`define IPSC_ADDR_EN 3'h3
`define IPSC_ADDR_SENSE 3'h4
`define IPSC_ADDR_CTRL 3'h5

// ***********************************************
// reset values and field layout
// ***********************************************
`define IPSC_RST_BYTE 8'h00
`define IPSC_EXT_N 6
`define IPSC_PEND_RO_MASK 8'h3f
`define IPSC_BIT_A_EXT0 7
`define IPSC_BIT_A_EXT1 6
`define IPSC_BIT_A_EXT23 5
`define IPSC_BIT_A_EXT45 4
`define IPSC_BIT_A_WDT_RFSH 3
`define IPSC_BIT_A_TMR0 2
`define IPSC_BIT_A_TMR1 1
`define IPSC_BIT_A_TMR2 0
`define IPSC_BIT_B_TMR3 7
`define IPSC_BIT_B_TMR4 6
`define IPSC_BIT_B_DMA 5
`define IPSC_BIT_B_SER0 3
`define IPSC_BIT_B_SER1 2
`define IPSC_BIT_B_ADC 1
`define IPSC_CTRL_STBY_BIT 0

`endif

// >>> ipsc_pkg.sv
// types for the interrupt priority and sense control block
// assumes ipsc_consts.svh on the include path
`default_nettype none

package ipsc_pkg;
  // bus slave answer states, gray along the path
  typedef enum logic [1:0] {
    IPSC_IDLE = 2'b00,
    IPSC_ACK = 2'b01
  } ipsc_bus_e;
  // one byte register
  typedef logic [7:0] ipsc_byte_t;
  // six external request lanes
  typedef logic [5:0] ipsc_ext_t;
  // seven internal group levels
  typedef logic [6:0] ipsc_grp_t;
endpackage

`default_nettype wire

// >>> ipsc_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output changes once stages two and three agree
`default_nettype none

module ipsc_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // raw pins, idle high
  input wire logic [WIDTH-1:0] i_pin,
  // filtered level
  output logic [WIDTH-1:0] o_level
);

  // ***********************************************
  // synchroniser chain
  // ***********************************************
  logic [WIDTH-1:0] s1_reg; // metastable stage, read only by s2
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // shift chain; reset to idle-high so no false edge at start
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a bit only when the last two stages agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= '1;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          o_level[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> ipsc_props.sv
// concurrent checks on the priority and sense control block ports
// assumes binding into ipsc_top, one clock, async active-low reset
`include "ipsc_consts.svh"
`default_nettype none

module ipsc_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // bus slave side
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // standby and core side
  input wire logic i_hw_standby,
  input wire ipsc_pkg::ipsc_ext_t o_ext_request,
  input wire ipsc_pkg::ipsc_ext_t o_ext_level,
  input wire logic [9:0] o_int_level
);
  import ipsc_pkg::*;
  // ****
  // one domain, so clock and disable once
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // a taken request gets its answer one cycle later
  a_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus answer late");
  // answer strobe lasts exactly one cycle
  a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer held too long");
  // outputs come out of reset cleared
  a_reset_clear: assert property ($rose(i_rstn) |-> o_ext_request == '0 && o_ext_level == '0 && o_int_level == '0)
    else $error("outputs not clear after reset");
  // long standby holds everything cleared
  a_stby_clear: assert property (i_hw_standby [*8] |-> o_ext_request == '0 && o_ext_level == '0 && o_int_level == '0)
    else $error("outputs not clear in standby");
  // first priority byte lands on the right lanes two cycles on
  a_pri_a_map: assert property (i_write && !o_waitrequest && i_byteenable[0] && i_address == `IPSC_ADDR_PRI_A |-> ##2
    {o_ext_level[0], o_ext_level[1], o_ext_level[2], o_ext_level[4], o_int_level[5], o_int_level[0],
     o_int_level[1], o_int_level[2]} == $past(i_writedata[7:0], 2))
    else $error("first priority byte misrouted");
  // second priority byte, bits 4 and 0 unused
  a_pri_b_map: assert property (i_write && !o_waitrequest && i_byteenable[0] && i_address == `IPSC_ADDR_PRI_B |-> ##2
    {o_int_level[3], o_int_level[4], o_int_level[6], o_int_level[7], o_int_level[8], o_int_level[9]} ==
    {$past(i_writedata[7:5], 2), $past(i_writedata[3:1], 2)})
    else $error("second priority byte misrouted");
  // shared levels for request pairs
  a_share_lvl: assert property (o_ext_level[5] == o_ext_level[4] && o_ext_level[3] == o_ext_level[2])
    else $error("paired request levels differ");
  // top two pending bits always read zero
  a_pend_hi_zero: assert property (i_read && !o_waitrequest && i_address == `IPSC_ADDR_PEND |-> o_readdata[7:6] == 2'b00)
    else $error("pending top bits nonzero");
  // unmapped words read zero
  a_unmap_zero: assert property (i_read && !o_waitrequest && i_address > `IPSC_ADDR_CTRL |-> o_readdata == '0)
    else $error("unmapped read nonzero");
endmodule

bind ipsc_top ipsc_props u_props (.i_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
  .o_readdata, .o_waitrequest, .i_hw_standby, .o_ext_request, .o_ext_level, .o_int_level);

`default_nettype wire

// >>> ipsc_core_model.sv
// behavioural core exception logic that takes shown requests
// assumes same clock as the block; enable input lets the bench hold it off
`default_nettype none

module ipsc_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // bench control
  input wire logic i_take_on,
  // requests in, acceptance pulses out
  input wire ipsc_pkg::ipsc_ext_t i_ext_request,
  output ipsc_pkg::ipsc_ext_t o_ext_accept
);
  import ipsc_pkg::*;
  logic [2:0] hold_reg; // gap so the flag has time to fall
  // take the lowest request, pulse one cycle, then pause
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_accept <= '0;
      hold_reg <= 3'h0;
    end else if (hold_reg != 3'h0) begin
      o_ext_accept <= '0;
      hold_reg <= hold_reg - 3'h1;
    end else if (i_take_on && |i_ext_request) begin
      o_ext_accept <= i_ext_request & (~i_ext_request + 6'h1);
      hold_reg <= 3'h6;
    end
  end
endmodule

`default_nettype wire

// >>> tb.sv
// self-checking bench for the priority and sense control block
// assumes ipsc_top, its checker and the core model are compiled first
`include "ipsc_consts.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ipsc_pkg::*;
  logic clk, rstn, rd, wr, stby, take_on, waitreq;
  logic [2:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  ipsc_ext_t pin_n, accept, req, lvl, m; // pins idle high
  logic [9:0] ilvl;
  logic [7:0] pat [3] = '{8'ha5, 8'h5a, 8'hff};
  int n_fail, num_checks;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ipsc_top u_dut (.i_clk(clk), .i_rstn(rstn), .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(waitreq), .i_hw_standby(stby),
    .i_ext_request_pin_n(pin_n), .i_ext_accept(accept), .o_ext_request(req), .o_ext_level(lvl), .o_int_level(ilvl));
  ipsc_core_model u_core (.i_clk(clk), .i_rstn(rstn), .i_take_on(take_on), .i_ext_request(req),
    .o_ext_accept(accept));

  // ****
  // bus and compare tasks
  // ****
  // one access, held until the answer edge, no local time limit
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // expected lanes from the two priority bytes
  function automatic ipsc_ext_t exp_ext(input logic [7:0] a);
    return {a[4], a[4], a[5], a[5], a[6], a[7]};
  endfunction
  function automatic logic [9:0] exp_int(input logic [7:0] a, input logic [7:0] b);
    return {b[1], b[2], b[3], b[5], a[3], b[6], b[7], a[0], a[1], a[2]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog, about twenty times the expected run
  initial begin
    #100000;
    n_fail++;
    $display("mismatch run expected finish seen watchdog");
    end_of_test();
  end

  // ****
  // test sequence
  // ****
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 3'h0;
    wdata = '0;
    be = 4'h1;
    stby = 1'b0;
    take_on = 1'b0;
    pin_n = '1;
    n_fail = 0;
    num_checks = 0;
    tick(12);
    rstn <= 1'b1;
    // every word, mapped or not, starts at zero
    for (int i = 0; i < 8; i++) rchk(3'(i), 8'h00, "reset word");
    chk("reset outs", 32'h0, {10'h0, req, lvl, ilvl});
    $display("test reset done");
    // priority bytes routed to their groups
    foreach (pat[i]) begin
      wreg(`IPSC_ADDR_PRI_A, pat[i]);
      wreg(`IPSC_ADDR_PRI_B, ~pat[i]);
      rchk(`IPSC_ADDR_PRI_A, pat[i], "pri a");
      rchk(`IPSC_ADDR_PRI_B, ~pat[i], "pri b");
      chk("ext level", 32'(exp_ext(pat[i])), 32'(lvl));
      chk("int level", 32'(exp_int(pat[i], ~pat[i])), 32'(ilvl));
    end
    be <= 4'h0;
    wreg(`IPSC_ADDR_PRI_A, 8'h00);
    be <= 4'h1;
    rchk(`IPSC_ADDR_PRI_A, 8'hff, "masked write");
    $display("test priority done");
    // spare bits stored; level flags set while enables are off
    wreg(`IPSC_ADDR_EN, 8'hc0);
    wreg(`IPSC_ADDR_SENSE, 8'hc0);
    rchk(`IPSC_ADDR_EN, 8'hc0, "enable spare");
    rchk(`IPSC_ADDR_SENSE, 8'hc0, "sense spare");
    wreg(`IPSC_ADDR_PEND, 8'hff);
    rchk(`IPSC_ADDR_PEND, 8'h00, "pend ones");
    pin_n <= '0;
    tick(10);
    chk("gated req", 32'h0, 32'(req));
    rchk(`IPSC_ADDR_PEND, 8'h3f, "level set");
    pin_n <= '1;
    tick(10);
    wreg(`IPSC_ADDR_PEND, 8'h00);
    rchk(`IPSC_ADDR_PEND, 8'h00, "read clear");
    $display("test level done");
    // falling edge per pin, clear only after a read of one
    wreg(`IPSC_ADDR_SENSE, 8'h3f);
    wreg(`IPSC_ADDR_EN, 8'h3f);
    for (int n = 0; n < 6; n++) begin
      m = 6'h1 << n;
      pin_n <= ~m;
      tick(8);
      pin_n <= '1;
      tick(8);
      wreg(`IPSC_ADDR_PEND, 8'h00);
      rchk(`IPSC_ADDR_PEND, {2'b00, m}, "unread clear");
      chk("req", 32'(m), 32'(req));
      wreg(`IPSC_ADDR_PEND, 8'hff);
      rchk(`IPSC_ADDR_PEND, {2'b00, m}, "write one");
      wreg(`IPSC_ADDR_PEND, 8'h00);
      rchk(`IPSC_ADDR_PEND, 8'h00, "edge clear");
    end
    $display("test edge done");
    // core acceptance: edge clears, level only once the pin is high
    take_on <= 1'b1;
    pin_n <= 6'h3b;
    tick(8);
    pin_n <= '1;
    tick(20);
    rchk(`IPSC_ADDR_PEND, 8'h00, "accept edge");
    wreg(`IPSC_ADDR_SENSE, 8'h00);
    pin_n <= 6'h37;
    tick(20);
    rchk(`IPSC_ADDR_PEND, 8'h08, "accept low");
    pin_n <= '1;
    tick(20);
    rchk(`IPSC_ADDR_PEND, 8'h00, "accept high");
    take_on <= 1'b0;
    $display("test accept done");
    // hardware standby wipes the priority, pending, enable and sense words
    wreg(`IPSC_ADDR_SENSE, 8'hff);
    // leave a live request so the wipe has something to clear
    pin_n <= 6'h3e;
    tick(8);
    pin_n <= '1;
    chk("stby pre", 32'h1, 32'(req));
    stby <= 1'b1;
    tick(10);
    chk("stby outs", 32'h0, {10'h0, req, lvl, ilvl});
    stby <= 1'b0;
    tick(8);
    for (int i = 0; i < 5; i++) rchk(3'(i), 8'h00, "stby word");
    $display("test standby done");
    // software standby word also holds the first priority byte and the outputs clear
    wreg(`IPSC_ADDR_PRI_A, 8'h81);
    wreg(`IPSC_ADDR_CTRL, 8'h01);
    rchk(`IPSC_ADDR_CTRL, 8'h01, "soft word");
    rchk(`IPSC_ADDR_PRI_A, 8'h00, "soft clear");
    chk("soft outs", 32'h0, {10'h0, req, lvl, ilvl});
    wreg(`IPSC_ADDR_CTRL, 8'h00);
    rchk(`IPSC_ADDR_CTRL, 8'h00, "soft off");
    $display("test soft standby done");
    end_of_test();
  end
endmodule

`default_nettype wire
